// ===== logic/mcu_alu_instruction_decode.sv
// instruction decode and execute core with apb view of its registers
`timescale 1ns/1ps
`default_nettype none
module mcu_alu_instruction_decode
	import mcu_alu_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        rst_n_in,
	// configuration word, static strap
	input  wire logic [1:0]  config_word_in,
	// program memory
	output logic      [11:0] pm_addr_out,
	input  wire logic [11:0] pm_data_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic [3:0]  pstrb_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out
);

	core_state_t st;
	core_state_t next_st;

	////////////////////////////////////////////////////////////////////////
	// decode helpers

	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a[1:0] == 2'h0) &&
			(a >= FREG_BASE || a == CTRL_OFS || a == W_OFS ||
			 a == STATUS_OFS || a == PC_OFS);
	endfunction : addr_mapped

	function automatic logic is_freg(input logic [7:0] a);
		is_freg = (a >= FREG_BASE) && (a[1:0] == 2'h0);
	endfunction : is_freg

	logic [5:0]  op6;
	logic [3:0]  op4;
	logic        dest_f;
	logic [4:0]  fa;
	logic [2:0]  bsel;
	logic [7:0]  lit;
	logic [7:0]  fsrc;
	logic        bitval;
	logic        tick;
	logic        exec;
	logic        apb_wr;
	logic        apb_setup;
	logic [7:0]  opb;
	logic        cbit;
	logic [8:0]  sum9;
	logic [4:0]  sum5;
	logic [7:0]  swapped;

	assign op6       = pm_data_in[11:6];
	assign op4       = pm_data_in[11:8];
	assign dest_f    = pm_data_in[5];
	assign fa        = pm_data_in[4:0];
	assign bsel      = pm_data_in[7:5];
	assign lit       = pm_data_in[7:0];
	assign fsrc      = st.fregs[fa];
	assign bitval    = fsrc[bsel];
	assign swapped   = {fsrc[3:0], fsrc[7:4]};
	assign apb_wr    = psel_in && penable_in && pwrite_in;
	assign apb_setup = psel_in && !penable_in;
	// the divider only counts once the strap is captured
	assign tick = st.run && st.cfg_done &&
		(st.mode == MODE_DIV1 || st.phase == DIV4_LAST);
	assign exec = tick && !st.skip && !apb_wr;

	// add uses w, subtract uses ~w; carry-in only when the option allows
	assign opb  = (op6 == OP_SUB) ? ~st.w : st.w;
	assign cbit = (op6 == OP_SUB) ? (st.cin ? st.c : 1'b1)
		: (st.cin && st.c);
	assign sum9 = 9'(fsrc) + 9'(opb) + 9'(cbit);
	assign sum5 = 5'(fsrc[3:0]) + 5'(opb[3:0]) + 5'(cbit);

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [7:0] res;
		logic       wr_res;
		logic       upd_z;
		logic       upd_cdc;
		logic       upd_c;
		logic       new_c;
		logic       take_skip;
		logic [4:0] idx;
		res       = 8'h00;
		wr_res    = 1'b0;
		upd_z     = 1'b0;
		upd_cdc   = 1'b0;
		upd_c     = 1'b0;
		new_c     = 1'b0;
		take_skip = 1'b0;
		idx       = paddr_in[6:2];
		next_st   = st;

		// strap: two flops, then a settle count before capture
		next_st.cfg_meta = config_word_in;
		next_st.cfg_sync = st.cfg_meta;
		if (!st.cfg_done) begin
			if (st.cfg_cnt == CFG_SETTLE) begin
				next_st.cfg_done = 1'b1;
				next_st.mode     = clk_mode_t'(st.cfg_sync[CFG_DIV4_BIT]);
				next_st.cin      = st.cfg_sync[CFG_CIN_BIT];
			end else begin
				next_st.cfg_cnt = st.cfg_cnt + 2'h1;
			end
		end

		if (st.run && st.cfg_done && st.mode == MODE_DIV4) begin
			next_st.phase = st.phase + 2'h1;
		end else begin
			next_st.phase = 2'h0;
		end

		case (op6)
			OP_MOVE_TO_F: begin
				res    = st.w;
				wr_res = dest_f;
			end
			OP_CLEAR: begin
				res    = 8'h00;
				wr_res = dest_f || (pm_data_in == CLEAR_W_WORD);
				upd_z  = wr_res;
			end
			OP_SUB, OP_ADD: begin
				res     = sum9[7:0];
				wr_res  = 1'b1;
				upd_z   = 1'b1;
				upd_cdc = 1'b1;
			end
			OP_DEC: begin
				res    = fsrc - 8'h01;
				wr_res = 1'b1;
				upd_z  = 1'b1;
			end
			OP_OR: begin
				res    = fsrc | st.w;
				wr_res = 1'b1;
				upd_z  = 1'b1;
			end
			OP_AND: begin
				res    = fsrc & st.w;
				wr_res = 1'b1;
				upd_z  = 1'b1;
			end
			OP_XOR: begin
				res    = fsrc ^ st.w;
				wr_res = 1'b1;
				upd_z  = 1'b1;
			end
			OP_MOVE_TEST: begin
				res    = fsrc;
				wr_res = 1'b1;
				upd_z  = 1'b1;
			end
			OP_NOT: begin
				res    = ~fsrc;
				wr_res = 1'b1;
				upd_z  = 1'b1;
			end
			OP_INC: begin
				res    = fsrc + 8'h01;
				wr_res = 1'b1;
				upd_z  = 1'b1;
			end
			OP_DEC_SKIP: begin
				res       = fsrc - 8'h01;
				wr_res    = 1'b1;
				take_skip = (res == 8'h00);
			end
			OP_INC_SKIP: begin
				res       = fsrc + 8'h01;
				wr_res    = 1'b1;
				take_skip = (res == 8'h00);
			end
			OP_ROT_RIGHT: begin
				res    = {st.c, fsrc[7:1]};
				wr_res = 1'b1;
				upd_c  = 1'b1;
				new_c  = fsrc[0];
			end
			OP_ROT_LEFT: begin
				res    = {fsrc[6:0], st.c};
				wr_res = 1'b1;
				upd_c  = 1'b1;
				new_c  = fsrc[7];
			end
			OP_NIB_SWAP: begin
				res    = swapped;
				wr_res = 1'b1;
			end
			default: begin
				res    = 8'h00;
				wr_res = 1'b0;
			end
		endcase

		// literal and bit groups sit above the six-bit table
		case (op4)
			OP_BIT_CLEAR, OP_BIT_SET: begin
				res         = fsrc;
				res[bsel]   = (op4 == OP_BIT_SET);
				wr_res      = 1'b0;
				upd_z       = 1'b0;
				if (exec) begin
					next_st.fregs[fa] = res;
				end
			end
			OP_SKIP_BIT0: begin
				wr_res    = 1'b0;
				upd_z     = 1'b0;
				take_skip = !bitval;
			end
			OP_SKIP_BIT1: begin
				wr_res    = 1'b0;
				upd_z     = 1'b0;
				take_skip = bitval;
			end
			OP_LIT_MOVE, OP_LIT_OR, OP_LIT_AND, OP_LIT_XOR: begin
				upd_z = (op4 != OP_LIT_MOVE);
				case (op4)
					OP_LIT_OR:  res = st.w | lit;
					OP_LIT_AND: res = st.w & lit;
					OP_LIT_XOR: res = st.w ^ lit;
					default:    res = lit;
				endcase
				if (exec) begin
					next_st.w = res;
				end
				wr_res = 1'b0;
			end
			4'h8, 4'h9, 4'ha, 4'hb: begin
				// branches are outside this core: they retire as no-ops
				wr_res = 1'b0;
				upd_z  = 1'b0;
			end
			default: begin
			end
		endcase

		if (exec) begin
			if (wr_res) begin
				if (dest_f) begin
					next_st.fregs[fa] = res;
				end else begin
					next_st.w = res;
				end
			end
			if (upd_z) begin
				next_st.z = (res == 8'h00);
			end
			if (upd_cdc) begin
				next_st.c  = sum9[8];
				next_st.dc = sum5[4];
			end
			if (upd_c) begin
				next_st.c = new_c;
			end
			next_st.skip = take_skip;
		end else if (tick && st.skip && !apb_wr) begin
			// a skipped page or bank select drags the next one along
			next_st.skip = (pm_data_in[11:4] == PAGE_BANK_HI);
		end
		if (tick && !apb_wr) begin
			next_st.pc = st.pc + 12'h001;
		end

		// apb side: read data and error are captured in the setup cycle
		if (apb_setup) begin
			next_st.slverr = !addr_mapped(paddr_in);
			next_st.prdata = 32'h0000_0000;
			if (is_freg(paddr_in)) begin
				next_st.prdata = {24'h000000, st.fregs[idx]};
			end else begin
				case (paddr_in)
					CTRL_OFS: begin
						next_st.prdata[CTRL_RUN_BIT]  = st.run;
						next_st.prdata[CTRL_DIV4_BIT] = (st.mode == MODE_DIV4);
						next_st.prdata[CTRL_CIN_BIT]  = st.cin;
					end
					W_OFS: next_st.prdata = {24'h000000, st.w};
					STATUS_OFS: begin
						next_st.prdata[ST_CARRY_BIT] = st.c;
						next_st.prdata[ST_DIGIT_BIT] = st.dc;
						next_st.prdata[ST_ZERO_BIT]  = st.z;
						next_st.prdata[ST_SKIP_BIT]  = st.skip;
					end
					PC_OFS: next_st.prdata = {20'h00000, st.pc};
					default: next_st.prdata = 32'h0000_0000;
				endcase
			end
		end
		// software writes win over the core; the core is held that cycle
		if (apb_wr && addr_mapped(paddr_in)) begin
			if (is_freg(paddr_in)) begin
				if (pstrb_in[0]) begin
					next_st.fregs[idx] = pwdata_in[7:0];
				end
			end else begin
				case (paddr_in)
					CTRL_OFS: begin
						if (pstrb_in[0]) begin
							next_st.run = pwdata_in[CTRL_RUN_BIT];
						end
					end
					W_OFS: begin
						if (pstrb_in[0]) begin
							next_st.w = pwdata_in[7:0];
						end
					end
					STATUS_OFS: begin
						if (pstrb_in[0]) begin
							next_st.c    = pwdata_in[ST_CARRY_BIT];
							next_st.dc   = pwdata_in[ST_DIGIT_BIT];
							next_st.z    = pwdata_in[ST_ZERO_BIT];
							next_st.skip = pwdata_in[ST_SKIP_BIT];
						end
					end
					PC_OFS: begin
						if (pstrb_in[0]) begin
							next_st.pc[7:0] = pwdata_in[7:0];
						end
						if (pstrb_in[1]) begin
							next_st.pc[11:8] = pwdata_in[11:8];
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			st       <= '0;
			st.pc    <= PC_RESET;
			st.w     <= W_RESET;
			st.mode  <= MODE_DIV1;
		end else begin
			st <= next_st;
		end
	end

	assign pm_addr_out = st.pc;
	assign prdata_out  = st.prdata;
	assign pready_out  = 1'b1;
	assign pslverr_out = st.slverr;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	logic [7:0] fsrc_q;
	logic [4:0] fa_q;
	logic [7:0] lit_q;
	logic [7:0] w_q;
	always_ff @(posedge ref_clk_in) begin
		fsrc_q <= fsrc;
		fa_q   <= fa;
		lit_q  <= lit;
		w_q    <= st.w;
	end

	// a run bit cleared inside the gap ends the spacing check quietly
	sequence div4_gap;
		!tick [*3] ##1 (tick || !st.run);
	endsequence

	sequence skip_armed;
		st.skip ##0 $stable(st.c) ##0 $stable(st.z);
	endsequence

	AST_LIT_AND: assert property (exec && op4 == OP_LIT_AND
		|=> st.w == (w_q & lit_q))
		else $error("literal and gave wrong w");
	AST_AND_F: assert property (exec && op6 == OP_AND && dest_f
		|=> st.fregs[fa_q] == (fsrc_q & w_q) && st.z == (st.fregs[fa_q] == 8'h00))
		else $error("and into file register wrong");
	AST_NOT_F: assert property (exec && op6 == OP_NOT && dest_f
		|=> st.fregs[fa_q] == ~fsrc_q)
		else $error("complement wrong");
	AST_ADD_C: assert property (exec && op6 == OP_ADD && !st.cin
		|=> st.c == (({1'b0, fsrc_q} + {1'b0, w_q}) > 9'h0ff))
		else $error("add carry wrong");
	AST_ROT_L: assert property (exec && op6 == OP_ROT_LEFT
		|=> st.c == fsrc_q[7] && $stable(st.z))
		else $error("rotate left carry wrong");
	AST_SWAP: assert property (exec && op6 == OP_NIB_SWAP && dest_f
		|=> st.fregs[fa_q] == {fsrc_q[3:0], fsrc_q[7:4]} && $stable(st.c))
		else $error("nibble swap wrong");
	AST_DEC_SKIP: assert property (exec && op6 == OP_DEC_SKIP && fsrc == 8'h01
		|=> skip_armed)
		else $error("decrement to zero did not skip");
	AST_SKIP_ONE: assert property (exec && op4 == OP_SKIP_BIT1 && bitval
		|=> st.skip)
		else $error("bit set did not skip");
	AST_SKIP_ZERO: assert property (exec && op4 == OP_SKIP_BIT0 && bitval
		|=> !st.skip)
		else $error("bit set was skipped on clear test");
	AST_PAGE_SKIP: assert property (tick && st.skip && !apb_wr &&
		pm_data_in[11:4] == PAGE_BANK_HI |=> st.skip)
		else $error("page select after skip not chained");
	AST_DIV4: assert property (tick && st.mode == MODE_DIV4 |=> div4_gap)
		else $error("divide by four spacing wrong");
	AST_DIV1: assert property (st.mode == MODE_DIV1 && st.run && st.cfg_done &&
		!apb_wr |=> st.pc == $past(st.pc) + 12'h001)
		else $error("one instruction per cycle lost");

endmodule : mcu_alu_instruction_decode
`default_nettype wire

// ===== logic/mcu_alu_pkg.sv
// constants and types for the 12-bit instruction decode and execute core
//
// Notes on behaviour
// - AND of file register and W goes to file register or W; zero flag updated.
// - AND-immediate puts W AND eight-bit literal into W; zero flag updated.
// - inclusive OR, register, W and literal forms; zero flag updated.
// - exclusive OR, register, W and literal forms; zero flag updated.
// - complement puts the inverse of the file register into the file register or W; zero flag updated.
// - add and subtract update carry, digit carry and zero in one cycle.
// - decrement, store, skip next when zero; one or two cycles; no flags.
// - increment, store, skip next when zero; no flags changed.
// - rotate left through carry, top bit to carry, carry to bit zero.
// - rotate right through carry, bit zero to carry, carry to top bit.
// - swap nibbles of the file register into the file register or W; no flags changed.
// - skip next instruction when the selected bit is one; extra cycle.
// - skip next instruction when the selected bit is zero; no flags.
// - clear or set one selected bit; other bits and flags untouched.
// - one instruction per instruction cycle when nothing is skipped.
// - test-and-skip costs one cycle without skip, two with skip.
// - instruction cycle is oscillator divided by one or by four.
// - clock division comes from the configuration word, not a register.
// - a skipped page or bank select also skips the next instruction.
// - carry-in to add and subtract only when the configuration enables it.
package mcu_alu_pkg;
	// apb register offsets (byte addresses)
	localparam logic [7:0]  CTRL_OFS       = 8'h00;
	localparam logic [7:0]  W_OFS          = 8'h04;
	localparam logic [7:0]  STATUS_OFS     = 8'h08;
	localparam logic [7:0]  PC_OFS         = 8'h0c;
	localparam logic [7:0]  FREG_BASE      = 8'h80;
	// field positions
	localparam int          CTRL_RUN_BIT   = 0;
	localparam int          CTRL_DIV4_BIT  = 8;
	localparam int          CTRL_CIN_BIT   = 9;
	localparam int          ST_CARRY_BIT   = 0;
	localparam int          ST_DIGIT_BIT   = 1;
	localparam int          ST_ZERO_BIT    = 2;
	localparam int          ST_SKIP_BIT    = 3;
	localparam int          CFG_DIV4_BIT   = 0;
	localparam int          CFG_CIN_BIT    = 1;
	// values after reset and counts
	localparam logic [11:0] PC_RESET       = 12'h000;
	localparam logic [7:0]  W_RESET        = 8'h00;
	localparam logic [1:0]  CFG_SETTLE     = 2'h3;
	localparam logic [1:0]  DIV4_LAST      = 2'h3;
	// six-bit opcode groups, instruction bits 11:6
	localparam logic [5:0]  OP_MOVE_TO_F   = 6'h00;
	localparam logic [5:0]  OP_CLEAR       = 6'h01;
	localparam logic [5:0]  OP_SUB         = 6'h02;
	localparam logic [5:0]  OP_DEC         = 6'h03;
	localparam logic [5:0]  OP_OR          = 6'h04;
	localparam logic [5:0]  OP_AND         = 6'h05;
	localparam logic [5:0]  OP_XOR         = 6'h06;
	localparam logic [5:0]  OP_ADD         = 6'h07;
	localparam logic [5:0]  OP_MOVE_TEST   = 6'h08;
	localparam logic [5:0]  OP_NOT         = 6'h09;
	localparam logic [5:0]  OP_INC         = 6'h0a;
	localparam logic [5:0]  OP_DEC_SKIP    = 6'h0b;
	localparam logic [5:0]  OP_ROT_RIGHT   = 6'h0c;
	localparam logic [5:0]  OP_ROT_LEFT    = 6'h0d;
	localparam logic [5:0]  OP_NIB_SWAP    = 6'h0e;
	localparam logic [5:0]  OP_INC_SKIP    = 6'h0f;
	// four-bit opcode groups, instruction bits 11:8
	localparam logic [3:0]  OP_BIT_CLEAR   = 4'h4;
	localparam logic [3:0]  OP_BIT_SET     = 4'h5;
	localparam logic [3:0]  OP_SKIP_BIT0   = 4'h6;
	localparam logic [3:0]  OP_SKIP_BIT1   = 4'h7;
	localparam logic [3:0]  OP_LIT_MOVE    = 4'hc;
	localparam logic [3:0]  OP_LIT_OR      = 4'hd;
	localparam logic [3:0]  OP_LIT_AND     = 4'he;
	localparam logic [3:0]  OP_LIT_XOR     = 4'hf;
	localparam logic [11:0] CLEAR_W_WORD   = 12'h040;
	localparam logic [7:0]  PAGE_BANK_HI   = 8'h01;

	typedef enum logic {
		MODE_DIV1 = 1'b0,
		MODE_DIV4 = 1'b1
	} clk_mode_t;

	typedef struct packed {
		logic [31:0][7:0] fregs;
		logic [11:0]      pc;
		logic [7:0]       w;
		logic             c;
		logic             dc;
		logic             z;
		logic             skip;
		logic [1:0]       phase;
		logic             run;
		clk_mode_t        mode;
		logic             cin;
		logic [1:0]       cfg_meta;
		logic [1:0]       cfg_sync;
		logic [1:0]       cfg_cnt;
		logic             cfg_done;
		logic [31:0]      prdata;
		logic             slverr;
	} core_state_t;
endpackage : mcu_alu_pkg

// ===== tb/prog_mem_model.sv
// program memory model: combinational word read for the core's fetch port
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
	// fetch port
	input  wire logic [11:0] addr_in,
	output logic      [11:0] data_out
);
	logic [11:0] mem [0:4095];

	// unwritten words hold the no-op pattern so a run past the program is inert
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 12'h000;
		end
	end

	// same-cycle read: the core executes the word on its tick edge
	assign data_out = mem[addr_in];
endmodule : prog_mem_model
`default_nettype wire

// ===== tb/tb_mcu_alu_instruction_decode.sv
// self-checking bench for the instruction decode and execute core
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
	end \
end
module tb_mcu_alu_instruction_decode import mcu_alu_pkg::*;;
	typedef struct packed {
		logic [11:0] op;
		logic [7:0]  w;
		logic [7:0]  f;
		logic [3:0]  st;
		logic [7:0]  ew;
		logic [7:0]  ef;
		logic [3:0]  est;
		logic [7:0]  e2;
	} row_t;

	logic        ref_clk = 1'b0;
	logic        rst_n   = 1'b0;
	logic [1:0]  cfg     = 2'h0;
	logic [11:0] pm_addr;
	logic [11:0] pm_data;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] rd;
	logic        err;
	int          num_errors  = 0;
	int          comparisons = 0;

	// cases: opcode, W, file reg 1, status in, then W, file reg 1, status, reg 2
	row_t rows [28] = '{
		'{12'h161, 8'h0f, 8'h3c, 4'h0, 8'h0f, 8'h0c, 4'h0, 8'h01},
		'{12'h141, 8'hf0, 8'h0f, 4'h0, 8'h00, 8'h0f, 4'h4, 8'h01},
		'{12'he3c, 8'h0f, 8'h55, 4'h0, 8'h0c, 8'h55, 4'h0, 8'h01},
		'{12'h121, 8'h01, 8'h80, 4'h0, 8'h01, 8'h81, 4'h0, 8'h01},
		'{12'h101, 8'h02, 8'h10, 4'h0, 8'h12, 8'h10, 4'h0, 8'h01},
		'{12'hd00, 8'h00, 8'h00, 4'h0, 8'h00, 8'h00, 4'h4, 8'h01},
		'{12'h1a1, 8'hff, 8'hff, 4'h0, 8'hff, 8'h00, 4'h4, 8'h01},
		'{12'h181, 8'h0f, 8'hf0, 4'h0, 8'hff, 8'hf0, 4'h0, 8'h01},
		'{12'hfaa, 8'h55, 8'h00, 4'h0, 8'hff, 8'h00, 4'h0, 8'h01},
		'{12'h261, 8'h00, 8'hff, 4'h0, 8'h00, 8'h00, 4'h4, 8'h01},
		'{12'h1e1, 8'h08, 8'h08, 4'h0, 8'h08, 8'h10, 4'h2, 8'h01},
		'{12'h1c1, 8'h80, 8'h80, 4'h0, 8'h00, 8'h80, 4'h5, 8'h01},
		'{12'h0a1, 8'h05, 8'h05, 4'h0, 8'h05, 8'h00, 4'h7, 8'h01},
		'{12'h0a1, 8'h01, 8'h00, 4'h0, 8'h01, 8'hff, 4'h0, 8'h01},
		'{12'h2e1, 8'h00, 8'h01, 4'h1, 8'h00, 8'h00, 4'h1, 8'h00},
		'{12'h2e1, 8'h00, 8'h02, 4'h4, 8'h00, 8'h01, 4'h4, 8'h01},
		'{12'h3e1, 8'h00, 8'hff, 4'h0, 8'h00, 8'h00, 4'h0, 8'h00},
		'{12'h3e1, 8'h00, 8'h10, 4'h0, 8'h00, 8'h11, 4'h0, 8'h01},
		'{12'h361, 8'h00, 8'h40, 4'h1, 8'h00, 8'h81, 4'h0, 8'h01},
		'{12'h321, 8'h00, 8'h01, 4'h0, 8'h00, 8'h00, 4'h1, 8'h01},
		'{12'h3a1, 8'h00, 8'h12, 4'h7, 8'h00, 8'h21, 4'h7, 8'h01},
		'{12'h7e1, 8'h00, 8'h80, 4'h0, 8'h00, 8'h80, 4'h0, 8'h00},
		'{12'h701, 8'h00, 8'hfe, 4'h0, 8'h00, 8'hfe, 4'h0, 8'h01},
		'{12'h6e1, 8'h00, 8'h7f, 4'h0, 8'h00, 8'h7f, 4'h0, 8'h00},
		'{12'h601, 8'h00, 8'h01, 4'h0, 8'h00, 8'h01, 4'h0, 8'h01},
		'{12'h461, 8'h00, 8'hff, 4'h7, 8'h00, 8'hf7, 4'h7, 8'h01},
		'{12'h5c1, 8'h00, 8'h00, 4'h0, 8'h00, 8'h40, 4'h0, 8'h01},
		'{12'h021, 8'h3c, 8'h00, 4'h0, 8'h3c, 8'h3c, 4'h0, 8'h01}
	};

	mcu_alu_instruction_decode dut_u (
		.ref_clk_in     (ref_clk),
		.rst_n_in       (rst_n),
		.config_word_in (cfg),
		.pm_addr_out    (pm_addr),
		.pm_data_in     (pm_data),
		.psel_in        (psel),
		.penable_in     (penable),
		.pwrite_in      (pwrite),
		.paddr_in       (paddr),
		.pwdata_in      (pwdata),
		.pstrb_in       (4'hf),
		.prdata_out     (prdata),
		.pready_out     (pready),
		.pslverr_out    (pslverr)
	);

	prog_mem_model mem_u (
		.addr_in  (pm_addr),
		.data_out (pm_data)
	);

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////
	// always entered just after a rising edge; ends one edge after the access
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	// word 0 under test, the following words mark whether it skipped
	task automatic run_row(input row_t r);
		mem_u.mem[0] = r.op;
		apb(1'b1, W_OFS, {24'h0, r.w});
		apb(1'b1, FREG_BASE + 8'h04, {24'h0, r.f});
		apb(1'b1, FREG_BASE + 8'h08, 32'h0);
		apb(1'b1, STATUS_OFS, {28'h0, r.st});
		apb(1'b1, PC_OFS, 32'h0);
		apb(1'b1, CTRL_OFS, 32'h1);
		repeat (24) @(posedge ref_clk);
		apb(1'b1, CTRL_OFS, 32'h0);
		apb(1'b0, W_OFS, 32'h0);
		`CHK(rd, {24'h0, r.ew})
		apb(1'b0, FREG_BASE + 8'h04, 32'h0);
		`CHK(rd, {24'h0, r.ef})
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHK(rd, {28'h0, r.est})
		apb(1'b0, FREG_BASE + 8'h08, 32'h0);
		`CHK(rd, {24'h0, r.e2})
	endtask : run_row

	// cycles between pc 2 and pc 5, seen off the active edge
	task automatic rate(input int exp);
		int n;
		n = 0;
		apb(1'b1, PC_OFS, 32'h0);
		apb(1'b1, CTRL_OFS, 32'h1);
		while (pm_addr !== 12'h002) @(negedge ref_clk);
		while (pm_addr !== 12'h005) begin
			@(negedge ref_clk);
			n++;
		end
		`CHK(n, exp)
		@(posedge ref_clk);
		apb(1'b1, CTRL_OFS, 32'h0);
	endtask : rate

	task automatic end_of_test;
		$display("comparisons=%0d errors=%0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		num_errors++;
		end_of_test();
	end

	initial begin
		mem_u.mem[1] = 12'h502;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		apb(1'b0, CTRL_OFS, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, PC_OFS, 32'h0);
		`CHK(rd, {20'h0, PC_RESET})
		apb(1'b0, 8'h10, 32'h0);
		`CHK({err, rd}, 33'h1_0000_0000)
		foreach (rows[i]) begin
			run_row(rows[i]);
		end
		rate(3);
		// a skipped page select drags the word after it along
		mem_u.mem[1] = 12'h010;
		mem_u.mem[2] = 12'h502;
		mem_u.mem[3] = 12'h522;
		run_row('{12'h2e1, 8'h0, 8'h01, 4'h0, 8'h0, 8'h0, 4'h0, 8'h02});
		// second reset with divided timing and carry-in strapped
		rst_n <= 1'b0;
		cfg   <= 2'h3;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		apb(1'b0, FREG_BASE + 8'h04, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, CTRL_OFS, 32'h0);
		`CHK(rd, 32'h300)
		rate(12);
		run_row('{12'h1e1, 8'h1, 8'h01, 4'h1, 8'h1, 8'h3, 4'h0, 8'h03});
		end_of_test();
	end
endmodule : tb_mcu_alu_instruction_decode
`default_nettype wire
